// ### msrs_board_model.sv
// board reset supervisor model: drives the power-on clear and warm reset pins
// assumes one reference clock shared with the sequencer; por_cmd and warm_cmd are one-cycle pulses, warm_hold is a level
`timescale 1ns/100ps

module msrs_board_model #(
  parameter int POR_LOW  = 256,
  parameter int WARM_LOW = 24
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // commands from the bench
  input  wire logic por_cmd,
  input  wire logic warm_cmd,
  input  wire logic warm_hold,
  // reset pins, active low
  output logic      por_n,
  output logic      warm_n
);
  logic [15:0] por_cnt_r;
  logic [15:0] warm_cnt_r;

  // pulse counters; power-up counts as a power-on request, supplies valid at release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      por_cnt_r  <= 16'(POR_LOW);
      warm_cnt_r <= 16'h0;
    end else begin
      por_cnt_r  <= por_cmd ? 16'(POR_LOW) : por_cnt_r - 16'(por_cnt_r != 16'h0);
      warm_cnt_r <= warm_cmd ? 16'(WARM_LOW) : warm_cnt_r - 16'(warm_cnt_r != 16'h0);
    end
  end

  // two separate pins, never tied; warm_hold stretches warm past power-on clear
  assign por_n  = (por_cnt_r == 16'h0);
  assign warm_n = (warm_cnt_r == 16'h0) && !warm_hold;
endmodule : msrs_board_model

// ### msrs_pkg.sv
// constants, state types and carrier structs of the multi-source reset sequencer
// assumes one 10 MHz primary reference clock and a synchronous active-high block reset
//
// Behaviour
// RULE_01: board holds power-on clear low until every supply is valid.
// RULE_02: after supplies settle, power-on clear stays low 256 secondary reference cycles.
// RULE_03: without secondary reference clock, power-on clear low 256 primary cycles instead.
// RULE_04: power-on clear floats all pins and resets everything, test logic included.
// RULE_05: after power-on reset, non-boot peripherals come up disabled until software enables.
// RULE_06: during power-on clear, core pll held in reset and unlocked, controller bypassed.
// RULE_07: during power-on clear, memory/ethernet pll held in reset, its clocks invalid.
// RULE_08: in-init status output stays low while the device is in reset.
// RULE_09: power-on clear rising latches config, sets default dividers, releases secondary pll.
// RULE_10: after init, status goes high and system clocks pause ten reference cycles.
// RULE_11: most logic leaves reset only with both inputs high; secondary pll excepted.
// RULE_12: board holds warm input low at least 24 primary reference cycles.
// RULE_13: warm reset equals power-on reset minus test logic and secondary pll.
// RULE_14: warm reset keeps pci pins if pci was enabled beforehand; others reset.
// RULE_15: warm reset bypasses and resets core pll; secondary pll stays locked.
// RULE_16: board keeps power-on clear high during warm reset; inputs never tied together.
// RULE_17: emulator system reset request, maskable, resets all but test logic.
// RULE_18: system reset keeps memory controller registers and peripheral enables.
// RULE_19: system reset leaves plls alone; status low, then high, then ten-cycle pause.
// RULE_20: system reset never relatches config; boot uses previously latched value.
// RULE_21: host or pci cpu reset resets only cpu; pci request resets pci pins.
// RULE_22: simultaneous requests: power-on, maximum, warm, system, cpu, highest first.
// RULE_23: last cause kept one-hot: bit0 power-on, bit1 warm, bit3 system.
// RULE_24: both reset inputs synchronised first; maximum reset is an internal request.
package msrs_pkg;

  // pause of the system clocks, in reference clock cycles
  localparam int          PAUSE_REF_CYC   = 10;
  // longest allowed init time, in primary reference cycles
  localparam int          INIT_MAX_CYC    = 150000;
  localparam int          CNT_W           = 18;

  // last-reset cause flags
  localparam int          CAUSE_W         = 4;
  localparam int          CAUSE_POR_BIT   = 0;
  localparam int          CAUSE_WARM_BIT  = 1;
  localparam int          CAUSE_SYS_BIT   = 3;
  localparam logic [3:0]  CAUSE_RST       = 4'h0;

  // configuration pin widths
  localparam int          CFG_W           = 23;
  localparam int          BOOT_W          = 4;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_POR_HOLD,
    ST_WARM_HOLD,
    ST_SYS_HOLD,
    ST_INIT,
    ST_PAUSE
  } msrs_state_t;

  typedef enum logic [1:0] {
    K_POR,
    K_WARM,
    K_SYS
  } msrs_kind_t;

  // reset requests other than the two pins
  typedef struct packed {
    logic max_req;
    logic sys_req;
    logic sys_mask;
    logic cpu_host_req;
    logic cpu_pci_req;
  } msrs_req_t;

  // reset outputs, active high
  typedef struct packed {
    logic test_emu;
    logic mmac_pll;
    logic core_pll;
    logic core_seq;
    logic mmac_seq;
    logic chip_logic;
    logic memctl_regs;
    logic memctl_fsm;
    logic periph_en;
    logic cpu;
  } msrs_rst_t;

  localparam msrs_rst_t   RST_ALL         = 10'h3ff;

  // pin group control
  typedef struct packed {
    logic pins_hiz;
    logic pci_hold;
    logic pci_rst;
    logic host_ready_o;
    logic host_ready_oe;
  } msrs_pin_t;

  localparam msrs_pin_t   PIN_RST         = 5'h12;

  typedef struct packed {
    logic [CFG_W-1:0]  misc;
    logic [BOOT_W-1:0] boot;
  } msrs_cfg_t;

  // whole state of the sequencer
  typedef struct packed {
    logic              por_meta;
    logic              por_s;
    logic              warm_meta;
    logic              warm_s;
    msrs_state_t       state;
    msrs_kind_t        kind;
    logic [CNT_W-1:0]  cnt;
    logic              pci_was_en;
    msrs_rst_t         rsts;
    msrs_pin_t         pins;
    logic              status_n;
    logic              pause;
    logic              default_div;
    msrs_cfg_t         cfg;
    logic [CAUSE_W-1:0] cause;
  } msrs_reg_t;

endpackage : msrs_pkg

// ### msrs_tb_top.sv
// self-checking bench of the reset sequencer with the board model on its pins
// assumes a 10 MHz reference clock and a shortened init time
`timescale 1ns/100ps

module msrs_tb_top;
  import msrs_pkg::*;
  localparam int INIT_SIM = 20;
  localparam int TMO      = 3000;
  typedef struct packed {
    msrs_req_t  rq;
    logic       cpu, chip, prst, oe, stat;
    logic [3:0] cause;
  } msrs_row_t;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              por_cmd = 1'b0, warm_cmd = 1'b0, warm_hold = 1'b0;
  logic              pci_enabled = 1'b0;
  logic              por_n, warm_n;
  msrs_req_t         req = '0;
  logic [CFG_W-1:0]  config_pins = 23'h2a5a5a;
  logic [BOOT_W-1:0] boot_select_pins = 4'h9;
  msrs_rst_t         rst_out;
  msrs_pin_t         pin_ctl;
  logic              in_init_status_n, sysclk_pause, default_div_load;
  msrs_cfg_t         latched_config_register;
  logic [CAUSE_W-1:0] reset_cause;
  logic [31:0]       saved;
  msrs_row_t         rows[4];
  int                mismatches = 0, compares = 0, cycles = 0, n;

  msrs_top #(.INIT_CYC(INIT_SIM)) i_msrs_top (.sys_clk(sys_clk), .rst(rst), .por_n(por_n),
    .warm_n(warm_n), .req(req), .pci_enabled(pci_enabled), .config_pins(config_pins),
    .boot_select_pins(boot_select_pins), .rst_out(rst_out), .pin_ctl(pin_ctl),
    .in_init_status_n(in_init_status_n), .sysclk_pause(sysclk_pause),
    .default_div_load(default_div_load), .latched_config_register(latched_config_register),
    .reset_cause(reset_cause));
  msrs_board_model i_msrs_board_model (.sys_clk(sys_clk), .rst(rst), .por_cmd(por_cmd),
    .warm_cmd(warm_cmd), .warm_hold(warm_hold), .por_n(por_n), .warm_n(warm_n));

  always #50 sys_clk = ~sys_clk;

  // hang guard; bound is a few times the expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TMO) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  // sample 1 ns after an edge so that edge's updates have landed
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick

  // hold release: divider load, config latch, init length, pause length
  task automatic release_seq();
    n = 0;
    while (default_div_load !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    chk_bit(default_div_load, 1'b1, "no divider load");
    chk_word(32'(latched_config_register), 32'({config_pins, boot_select_pins}), "cfg");
    chk_bit(rst_out.mmac_pll, 1'b0, "secondary pll held");
    chk_bit(rst_out.test_emu, 1'b0, "test logic held");
    chk_bit(pin_ctl.pins_hiz, 1'b0, "pins still floated");
    tick(1);
    chk_bit(default_div_load, 1'b0, "divider load too long");
    n = 1;
    while (sysclk_pause !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk_word(n, INIT_SIM, "init length");
    chk_bit(in_init_status_n, 1'b1, "status at pause");
    n = 0;
    while (sysclk_pause === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk_word(n, PAUSE_REF_CYC, "pause length");
    chk_bit(rst_out.cpu, 1'b0, "cpu still in reset");
  endtask : release_seq

  // wait until out of reset and clocks running
  task automatic wait_run();
    n = 0;
    while (!(in_init_status_n === 1'b1 && sysclk_pause === 1'b0 && rst_out.cpu === 1'b0)
           && n < 200) begin
      tick(1);
      n++;
    end
  endtask : wait_run

  initial begin
    // max, sys, mask, host, pci
    rows[0] = '{5'b01100, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0};
    rows[1] = '{5'b00010, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0};
    rows[2] = '{5'b00001, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'h0};
    rows[3] = '{5'b01000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h8};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    tick(3);
    chk_word(32'(rst_out), 32'(RST_ALL), "power-on resets");
    chk_bit(pin_ctl.pins_hiz, 1'b1, "pins not floated");
    chk_bit(in_init_status_n, 1'b0, "status in hold");
    release_seq();
    chk_bit(rst_out.periph_en, 1'b0, "peripheral enables");
    saved = 32'(latched_config_register);
    @(posedge sys_clk);
    config_pins      <= 23'h13c3c3;
    boot_select_pins <= 4'h6;
    // ordinary requests from the run state
    foreach (rows[i]) begin
      @(posedge sys_clk);
      req <= rows[i].rq;
      tick(1);
      chk_bit(rst_out.cpu, rows[i].cpu, "cpu reset");
      chk_bit(rst_out.chip_logic, rows[i].chip, "chip reset");
      chk_bit(rst_out.memctl_fsm, rows[i].chip, "memctl fsm");
      chk_bit(rst_out.memctl_regs, 1'b0, "memctl regs");
      chk_bit(rst_out.periph_en, 1'b0, "peripheral state");
      chk_bit(rst_out.core_pll, 1'b0, "pll disturbed");
      chk_bit(rst_out.test_emu, 1'b0, "test logic");
      chk_bit(pin_ctl.pci_rst, rows[i].prst, "pci pins");
      chk_bit(pin_ctl.host_ready_oe, rows[i].oe, "host ready drive");
      if (rows[i].oe) chk_bit(pin_ctl.host_ready_o, 1'b1, "host ready level");
      chk_bit(in_init_status_n, rows[i].stat, "status");
      chk_word(32'(reset_cause), 32'(rows[i].cause), "cause");
      @(posedge sys_clk);
      req <= '0;
      tick(1);
      wait_run();
      chk_bit(in_init_status_n, 1'b1, "not back in run");
    end
    chk_word(32'(latched_config_register), saved, "config relatched");
    // maximum reset together with a system request: maximum acts as warm
    @(posedge sys_clk);
    req <= 5'b11000;
    tick(1);
    chk_bit(rst_out.core_pll, 1'b1, "maximum lost to system");
    chk_bit(rst_out.memctl_regs, 1'b1, "maximum memctl regs");
    chk_word(32'(reset_cause), 32'h8, "maximum changed cause");
    @(posedge sys_clk);
    req <= '0;
    release_seq();
    // warm reset with pci enabled
    @(posedge sys_clk);
    pci_enabled <= 1'b1;
    warm_cmd    <= 1'b1;
    @(posedge sys_clk);
    warm_cmd <= 1'b0;
    tick(5);
    chk_bit(rst_out.core_pll, 1'b1, "core pll");
    chk_bit(rst_out.core_seq, 1'b1, "core sequencer");
    chk_bit(rst_out.mmac_seq, 1'b1, "secondary sequencer");
    chk_bit(rst_out.mmac_pll, 1'b0, "secondary pll reset");
    chk_bit(rst_out.test_emu, 1'b0, "test logic reset");
    chk_bit(rst_out.chip_logic, 1'b1, "chip logic");
    chk_bit(pin_ctl.pci_hold, 1'b1, "pci hold");
    chk_bit(in_init_status_n, 1'b0, "warm status");
    chk_word(32'(reset_cause), 32'h2, "warm cause");
    release_seq();
    // power-on, warm and system together; warm outlasts power-on clear
    @(posedge sys_clk);
    por_cmd   <= 1'b1;
    warm_hold <= 1'b1;
    @(posedge sys_clk);
    por_cmd <= 1'b0;
    // system request reaches the edge that takes the synchronised warm pin
    @(posedge sys_clk);
    req <= 5'b01000;
    tick(1);
    chk_word(32'(reset_cause), 32'h2, "warm over system cause");
    chk_bit(rst_out.core_pll, 1'b1, "warm over system pll");
    tick(3);
    chk_word(32'(reset_cause), 32'h1, "priority cause");
    chk_bit(rst_out.test_emu, 1'b1, "power-on test reset");
    tick(262);
    chk_bit(rst_out.mmac_pll, 1'b0, "secondary pll early");
    chk_bit(rst_out.chip_logic, 1'b1, "logic released early");
    chk_bit(in_init_status_n, 1'b0, "status early");
    chk_bit(pin_ctl.pci_rst, 1'b1, "pci pins after power-on");
    @(posedge sys_clk);
    warm_hold <= 1'b0;
    req       <= '0;
    release_seq();
    tally_and_finish();
  end
endmodule : msrs_tb_top

// ### msrs_top.sv
// multi-source reset sequencer: power-on, warm, system and cpu reset sequencing
// assumes sys_clk is the primary reference clock; request inputs are synchronous to it
`timescale 1ns/100ps

module msrs_top import msrs_pkg::*; #(
  parameter int INIT_CYC = INIT_MAX_CYC
) (
  // clock and block reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // external reset pins, active low
  input  wire logic                 por_n,
  input  wire logic                 warm_n,
  // internal and emulator reset requests
  input  wire msrs_req_t            req,
  // pci enable state before a warm reset
  input  wire logic                 pci_enabled,
  // configuration straps
  input  wire logic [CFG_W-1:0]     config_pins,
  input  wire logic [BOOT_W-1:0]    boot_select_pins,
  // reset distribution
  output msrs_rst_t                 rst_out,
  // pin group control
  output msrs_pin_t                 pin_ctl,
  // status and clock control
  output logic                      in_init_status_n,
  output logic                      sysclk_pause,
  output logic                      default_div_load,
  // latched configuration and last cause
  output msrs_cfg_t                 latched_config_register,
  output logic [CAUSE_W-1:0]        reset_cause
);

  msrs_reg_t r;
  msrs_reg_t n;

  logic por_act;
  logic warm_act;
  logic sys_act;
  logic cpu_act;
  logic hold;
  logic por_hold;
  logic warm_hold;

  // request decode from synchronised pins; max reset joins the warm path
  assign por_act  = !r.por_s;
  assign warm_act = !r.warm_s || req.max_req;
  assign sys_act  = req.sys_req && !req.sys_mask;  // RULE_17
  assign cpu_act  = req.cpu_host_req || req.cpu_pci_req;

  // next state of the whole sequencer
  always_comb begin
    n = r;
    // two-flop synchronisers, first stage read only by the second
    n.por_meta    = por_n;        // RULE_24
    n.por_s       = r.por_meta;   // RULE_24
    n.warm_meta   = warm_n;       // RULE_24
    n.warm_s      = r.warm_meta;  // RULE_24
    n.default_div = 1'b0;
    if (por_act) begin  // RULE_22
      if (r.state != ST_POR_HOLD) begin
        n.state = ST_POR_HOLD;
        n.kind  = K_POR;
        n.cause = CAUSE_RST;
        n.cause[CAUSE_POR_BIT] = 1'b1;  // RULE_23
      end
    end else if (warm_act && r.state != ST_POR_HOLD && r.state != ST_WARM_HOLD) begin  // RULE_22
      n.state      = ST_WARM_HOLD;
      n.kind       = K_WARM;
      n.pci_was_en = pci_enabled;  // RULE_14
      // maximum reset has no flag of its own, so the cause is kept
      if (!r.warm_s) begin
        n.cause = CAUSE_RST;
        n.cause[CAUSE_WARM_BIT] = 1'b1;  // RULE_23
      end
    end else if (sys_act && r.state == ST_RUN) begin  // RULE_22
      n.state = ST_SYS_HOLD;
      n.kind  = K_SYS;
      n.cause = CAUSE_RST;
      n.cause[CAUSE_SYS_BIT] = 1'b1;  // RULE_23
    end else begin
      unique case (r.state)
        ST_POR_HOLD: begin
          // power-on clear released: latch straps, default dividers
          n.cfg         = '{misc: config_pins, boot: boot_select_pins};  // RULE_09
          n.default_div = 1'b1;  // RULE_09
          n.cnt         = '0;
          if (warm_act) begin
            n.state      = ST_WARM_HOLD;  // RULE_11
            n.pci_was_en = 1'b0;
          end else begin
            n.state = ST_INIT;
          end
        end
        ST_WARM_HOLD: begin
          if (!warm_act) begin
            n.cfg         = '{misc: config_pins, boot: boot_select_pins};
            n.default_div = 1'b1;
            n.cnt         = '0;
            n.state       = ST_INIT;  // RULE_11
          end
        end
        ST_SYS_HOLD: begin
          // straps stay as latched before
          if (!sys_act) begin
            n.cnt   = '0;
            n.state = ST_INIT;  // RULE_20
          end
        end
        ST_INIT: begin
          if (r.cnt == CNT_W'(INIT_CYC - 1)) begin
            n.cnt   = '0;
            n.state = ST_PAUSE;  // RULE_10
          end else begin
            n.cnt = r.cnt + 1'b1;
          end
        end
        ST_PAUSE: begin
          if (r.cnt == CNT_W'(PAUSE_REF_CYC - 1)) begin
            n.cnt   = '0;
            n.state = ST_RUN;  // RULE_10
          end else begin
            n.cnt = r.cnt + 1'b1;
          end
        end
        ST_RUN: begin
          n.cnt = '0;
        end
      endcase
    end

    // registered outputs follow the next state
    hold      = (n.state == ST_POR_HOLD) || (n.state == ST_WARM_HOLD) ||
                (n.state == ST_SYS_HOLD);
    por_hold  = (n.state == ST_POR_HOLD);
    warm_hold = (n.state == ST_WARM_HOLD);
    n.rsts.test_emu    = por_hold;                 // RULE_04
    n.rsts.mmac_pll    = por_hold;                 // RULE_07
    n.rsts.core_pll    = por_hold || warm_hold;    // RULE_06
    n.rsts.core_seq    = por_hold || warm_hold;    // RULE_15
    n.rsts.mmac_seq    = por_hold || warm_hold;    // RULE_15
    n.rsts.chip_logic  = hold;                     // RULE_13
    n.rsts.memctl_regs = por_hold || warm_hold;    // RULE_18
    n.rsts.memctl_fsm  = hold;                     // RULE_18
    n.rsts.periph_en   = por_hold || warm_hold;    // RULE_05
    // cpu held until the boot starts; cpu-only request acts in run
    n.rsts.cpu         = (n.state != ST_RUN) || cpu_act;  // RULE_21
    n.pins.pins_hiz      = por_hold;                           // RULE_04
    n.pins.pci_hold      = warm_hold && n.pci_was_en;          // RULE_14
    n.pins.pci_rst       = (warm_hold && !n.pci_was_en) ||
                           (n.state == ST_RUN && req.cpu_pci_req);  // RULE_21
    n.pins.host_ready_o  = 1'b1;
    n.pins.host_ready_oe = n.state == ST_RUN && req.cpu_pci_req;  // RULE_21
    n.status_n = !(hold || n.state == ST_INIT);    // RULE_08
    n.pause    = (n.state == ST_PAUSE);            // RULE_19
  end

  // state register; reset behaves like a power-on hold
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '{por_meta: 1'b0, por_s: 1'b0, warm_meta: 1'b0, warm_s: 1'b0,
             state: ST_POR_HOLD, kind: K_POR, cnt: '0, pci_was_en: 1'b0,
             rsts: RST_ALL, pins: PIN_RST, status_n: 1'b0, pause: 1'b0,
             default_div: 1'b0, cfg: '0, cause: CAUSE_RST};
    end else begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign rst_out                 = r.rsts;
  assign pin_ctl                 = r.pins;
  assign in_init_status_n        = r.status_n;
  assign sysclk_pause            = r.pause;
  assign default_div_load        = r.default_div;
  assign latched_config_register = r.cfg;
  assign reset_cause             = r.cause;

  // checks on the sequencer
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  por_float_a: assert property ((!por_n)[*3] |=>  // RULE_04
      pin_ctl.pins_hiz && rst_out.test_emu && rst_out.chip_logic)
    else $error("power-on clear did not float pins and reset all");

  por_plls_a: assert property (r.state == ST_POR_HOLD |->  // RULE_06
      rst_out.core_pll && rst_out.mmac_pll && rst_out.periph_en)
    else $error("plls or peripheral enables not reset in power-on hold");

  status_low_a: assert property ((r.state != ST_RUN && r.state != ST_PAUSE) |->  // RULE_08
      !in_init_status_n)
    else $error("status high while device in reset");

  por_release_a: assert property ((por_n && !warm_n)[*4] |=>  // RULE_11
      !rst_out.mmac_pll && rst_out.chip_logic)
    else $error("secondary pll not released alone while warm low");

  // helper: cycles the pause has stood so far; a counter instead of a long repetition
  logic [3:0] pause_run_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pause_run_r <= 4'h0;
    end else if (sysclk_pause) begin
      pause_run_r <= pause_run_r + 4'h1;
    end else begin
      pause_run_r <= 4'h0;
    end
  end

  // a pause cut short by a new hold is legal, so only a pause ending in run is measured
  pause_len_a: assert property (($fell(sysclk_pause) && r.state == ST_RUN) |->  // RULE_10
      pause_run_r == 4'(PAUSE_REF_CYC))
    else $error("clock pause is not ten cycles");

  pause_status_a: assert property (sysclk_pause |->  // RULE_10
      in_init_status_n && pause_run_r < 4'(PAUSE_REF_CYC))
    else $error("pause too long or status low during pause");

  cfg_latch_a: assert property ($changed(latched_config_register) |->  // RULE_09
      $past(r.state) == ST_POR_HOLD || $past(r.state) == ST_WARM_HOLD)
    else $error("config latched outside power-on or warm release");

  sys_keep_a: assert property (r.state == ST_SYS_HOLD |->  // RULE_19
      !rst_out.core_pll && !rst_out.mmac_pll && !rst_out.memctl_regs &&
      !rst_out.periph_en && !rst_out.test_emu && rst_out.memctl_fsm)
    else $error("system reset touched plls, registers or enables");

  sys_entry_a: assert property ((r.state == ST_RUN && por_n && warm_n && r.por_s &&  // RULE_17
      r.warm_s && !req.max_req && req.sys_req && !req.sys_mask) |=>
      r.state == ST_SYS_HOLD ##1 !in_init_status_n)
    else $error("unmasked system request not taken");

  warm_over_sys_a: assert property ((r.state == ST_RUN && r.por_s && !r.warm_s &&  // RULE_22
      req.sys_req) |=> r.state == ST_WARM_HOLD && reset_cause[CAUSE_WARM_BIT])
    else $error("system request won over warm reset");

  warm_plls_a: assert property (r.state == ST_WARM_HOLD && r.kind == K_WARM |->  // RULE_15
      rst_out.core_pll && !rst_out.mmac_pll && !rst_out.test_emu)
    else $error("warm reset pll handling wrong");

  pci_hold_a: assert property (r.state == ST_WARM_HOLD |->  // RULE_14
      pin_ctl.pci_hold == r.pci_was_en && pin_ctl.pci_rst == !r.pci_was_en)
    else $error("pci pins wrong in warm reset");

  cpu_only_a: assert property ((r.state == ST_RUN && r.por_s && r.warm_s &&  // RULE_21
      !req.max_req && !req.sys_req && req.cpu_host_req) |=>
      rst_out.cpu && !rst_out.chip_logic && in_init_status_n)
    else $error("cpu reset spread beyond the cpu");

  cause_hot_a: assert property ($onehot0(reset_cause) && !reset_cause[2])  // RULE_23
    else $error("reset cause not one-hot");

  sys_cfg_a: assert property (r.state == ST_SYS_HOLD |=>  // RULE_20
      $stable(latched_config_register))
    else $error("system reset relatched configuration");

  // main scenarios
  por_seq_c:  cover property (r.state == ST_POR_HOLD ##1 r.state == ST_INIT);
  warm_seq_c: cover property (r.state == ST_WARM_HOLD && r.kind == K_WARM ##1
                              r.state == ST_INIT);
  sys_seq_c:  cover property (r.state == ST_SYS_HOLD ##1 r.state == ST_INIT);
  cpu_rst_c:  cover property (r.state == ST_RUN && pin_ctl.host_ready_oe);

endmodule : msrs_top
